// *** verilog/cfg_loader_defines.vh ***
// Overview of operation
// - Port 5 boost in bits 1:0, default zero
// - Ports 4,3,2 boost at 7:6,5:4,3:2
// - Boost code gives 0, 4, 8, 12 percent
// - Register-reset bit restores configuration defaults
// - Register-reset bit self-clears, reads zero
// - Attach signals host, write-protects configuration range
// - Attach write-once; hardware resets set it, nothing clears it
// - Status defaults: attach one, others zero
// - Load after bus, power, hardware, software reset
// - Read byte 0, proceed only on A5
// - Other signature means memory absent, skip load
// - No signature: use hardware default values
// - Power or hardware reset loads hub and Ethernet
// - Bus reset reloads only the MAC address
// - Software reset or reload: Ethernet bytes only
// - MAC from bytes 01h to 06h ascending
// - Full-speed polling interval from byte 07h
// - High-speed polling interval from byte 08h
// - Ethernet configuration flags from byte 09h
// - Second boost register from byte 33h
// - Status register from byte 39h on hub load
`ifndef CFG_LOADER_DEFINES_VH
`define CFG_LOADER_DEFINES_VH

// -----------------------------------------------------------------------------
// Register byte addresses on the Avalon-MM bus.
// -----------------------------------------------------------------------------
`define ADDR_BOOST5        8'h00
`define ADDR_PORTS_4_TO_2_DRIVE_BOOST       8'h04
`define ADDR_ATTACH_CTRL   8'h08
`define ADDR_LOAD_STATUS   8'h0C
`define ADDR_MAC_LO        8'h10
`define ADDR_MAC_HI        8'h14
`define ADDR_ETH_PARAMS    8'h18
`define PROTECT_LAST       8'hFE

// -----------------------------------------------------------------------------
// Field positions and reset values.
// -----------------------------------------------------------------------------
`define BOOST5_MASK        8'h03
`define PORTS_4_TO_2_DRIVE_BOOST_MASK       8'hFC
`define CTRL_ATTACH_BIT    0
`define CTRL_REGRST_BIT    1
`define BOOST_RESET        8'h00
`define CTRL_RESET         8'h01
`define MAC_DEFAULT        48'hFFFFFFFFFFFF
`define FS_POLL_DEFAULT    8'h01
`define HS_POLL_DEFAULT    8'h04
`define ETH_FLAGS_DEFAULT  8'h05
`define MAX_POWER_DEFAULT  8'h01

// -----------------------------------------------------------------------------
// Serial memory layout.
// -----------------------------------------------------------------------------
`define MEM_SIGNATURE      8'hA5
`define MEM_SIG_ADDR       8'h00
`define MEM_MAC_FIRST      8'h01
`define MEM_MAC_LAST       8'h06
`define MEM_FS_POLL        8'h07
`define MEM_HS_POLL        8'h08
`define MEM_ETH_FLAGS      8'h09
`define MEM_BOOST5         8'h32
`define MEM_PORTS_4_TO_2_DRIVE_BOOST        8'h33
`define MEM_ATTACH_CTRL    8'h39

// -----------------------------------------------------------------------------
// Load kinds.
// -----------------------------------------------------------------------------
`define LOAD_FULL          2'h0
`define LOAD_ETH           2'h1
`define LOAD_MAC           2'h2

`endif

// *** verilog/eeprom_config_autoload.v ***
`timescale 1ns/1ps
`include "cfg_loader_defines.vh"

module eeprom_config_autoload (
  input  wire        mclk,
  input  wire        rst,
  input  wire        clk_en,
  input  wire        external_hw_reset_n,
  input  wire        usb_bus_reset,
  input  wire        software_reset,
  input  wire        reload_cmd,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        mem_rd_req,
  output wire [7:0]  mem_addr,
  input  wire        mem_rd_valid,
  input  wire [7:0]  mem_rd_data,
  output wire [7:0]  port5_drive_boost,
  output wire [7:0]  ports_4_to_2_drive_boost,
  output wire [7:0]  attach_and_reset_control,
  output wire        usb_attach,
  output wire [4:0]  port5_drive_level,
  output wire [4:0]  port4_drive_level,
  output wire [4:0]  port3_drive_level,
  output wire [4:0]  port2_drive_level,
  output wire [47:0] mac_address,
  output wire [7:0]  fs_poll_interval,
  output wire [7:0]  hs_poll_interval,
  output wire [7:0]  eth_config_flags,
  output wire [7:0]  eth_max_power,
  output wire        config_ready,
  output wire        signature_valid
);

  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_SIG_REQ  = 3'h1;
  localparam [2:0] ST_SIG_WAIT = 3'h2;
  localparam [2:0] ST_BYTE_REQ = 3'h3;
  localparam [2:0] ST_BYTE_WAIT= 3'h4;

  reg  [7:0]  boost5_reg;
  reg  [7:0]  ports_4_to_2_drive_boost_reg;
  reg  [7:0]  ctrl_reg;
  reg  [47:0] mac_reg;
  reg  [7:0]  fs_poll_reg;
  reg  [7:0]  hs_poll_reg;
  reg  [7:0]  flags_reg;
  reg  [7:0]  max_power_reg;
  reg  [2:0]  state_reg;
  reg  [1:0]  kind_reg;
  reg  [7:0]  addr_reg;
  reg         req_reg;
  reg         ready_reg;
  reg         sig_ok_reg;
  reg         wait_reg;
  reg  [31:0] rdata_reg;
  wire [19:0] level_bus;
  reg  [1:0]  pend_kind_reg;
  reg         pend_reg;

  wire        hw_reset;
  wire        bus_ack;
  wire        bus_wr;
  wire        protect;
  wire        load_done_byte;
  wire [7:0]  next_addr;
  wire        last_byte;
  wire        sel_boost5;
  wire        sel_ports_4_to_2_drive_boost;
  wire        sel_ctrl;

  // -----------------------------------------------------------------------------
  // Register select decode.
  // -----------------------------------------------------------------------------
  assign sel_boost5  = (avs_address == `ADDR_BOOST5);
  assign sel_ports_4_to_2_drive_boost = (avs_address == `ADDR_PORTS_4_TO_2_DRIVE_BOOST);
  assign sel_ctrl    = (avs_address == `ADDR_ATTACH_CTRL);

  assign hw_reset = rst | ~external_hw_reset_n;
  assign bus_ack  = (avs_read | avs_write) & ~wait_reg;
  assign bus_wr   = avs_write & ~wait_reg;
  // -----------------------------------------------------------------------------
  // Write protection.
  // -----------------------------------------------------------------------------
  // attach write protect
  assign protect  = ctrl_reg[`CTRL_ATTACH_BIT] & (avs_address <= `PROTECT_LAST);
  assign load_done_byte = (state_reg == ST_BYTE_WAIT) & mem_rd_valid;

  // -----------------------------------------------------------------------------
  // Memory address sequencing.
  // -----------------------------------------------------------------------------
  // full load order
  assign next_addr = (addr_reg == `MEM_ETH_FLAGS) ? `MEM_BOOST5 :
                     (addr_reg == `MEM_PORTS_4_TO_2_DRIVE_BOOST)   ? `MEM_ATTACH_CTRL :
                     addr_reg + 8'h01;
  assign last_byte = ((kind_reg == `LOAD_MAC) && (addr_reg == `MEM_MAC_LAST)) ||
                     ((kind_reg == `LOAD_ETH) && (addr_reg == `MEM_ETH_FLAGS)) ||
                     (addr_reg == `MEM_ATTACH_CTRL);

  // -----------------------------------------------------------------------------
  // Loader state machine and trigger capture.
  // -----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (hw_reset) begin
      // load after power or hardware reset
      state_reg     <= ST_SIG_REQ;
      kind_reg      <= `LOAD_FULL;
      addr_reg      <= `MEM_SIG_ADDR;
      req_reg       <= 1'b0;
      ready_reg     <= 1'b0;
      sig_ok_reg    <= 1'b0;
      pend_reg      <= 1'b0;
      pend_kind_reg <= `LOAD_FULL;
    end else if (clk_en) begin
      if (software_reset | reload_cmd) begin
        pend_reg      <= 1'b1;
        pend_kind_reg <= `LOAD_ETH;
      end else if (usb_bus_reset && !(pend_reg && pend_kind_reg == `LOAD_ETH)) begin
        pend_reg      <= 1'b1;
        pend_kind_reg <= `LOAD_MAC;
      end
      case (state_reg)
        ST_IDLE: begin
          if (pend_reg && !(software_reset | reload_cmd | usb_bus_reset)) begin
            pend_reg  <= 1'b0;
            kind_reg  <= pend_kind_reg;
            ready_reg <= 1'b0;
            state_reg <= ST_SIG_REQ;
          end
        end
        ST_SIG_REQ: begin
          addr_reg  <= `MEM_SIG_ADDR;
          req_reg   <= 1'b1;
          state_reg <= ST_SIG_WAIT;
        end
        ST_SIG_WAIT: begin
          if (mem_rd_valid) begin
            req_reg <= 1'b0;
            if (mem_rd_data == `MEM_SIGNATURE) begin
              sig_ok_reg <= 1'b1;
              addr_reg   <= `MEM_MAC_FIRST;
              state_reg  <= ST_BYTE_REQ;
            end else begin
              sig_ok_reg <= 1'b0;
              ready_reg  <= 1'b1;
              state_reg  <= ST_IDLE;
            end
          end
        end
        ST_BYTE_REQ: begin
          req_reg   <= 1'b1;
          state_reg <= ST_BYTE_WAIT;
        end
        ST_BYTE_WAIT: begin
          if (mem_rd_valid) begin
            req_reg <= 1'b0;
            if (last_byte) begin
              ready_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              addr_reg  <= next_addr;
              state_reg <= ST_BYTE_REQ;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          req_reg   <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------------
  // Configuration registers.
  // -----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (hw_reset) begin
      boost5_reg    <= `BOOST_RESET;
      ports_4_to_2_drive_boost_reg   <= `BOOST_RESET;
      ctrl_reg      <= `CTRL_RESET;
      mac_reg       <= `MAC_DEFAULT;
      fs_poll_reg   <= `FS_POLL_DEFAULT;
      hs_poll_reg   <= `HS_POLL_DEFAULT;
      flags_reg     <= `ETH_FLAGS_DEFAULT;
      max_power_reg <= `MAX_POWER_DEFAULT;
    end else if (clk_en) begin
      if (ctrl_reg[`CTRL_REGRST_BIT]) begin
        boost5_reg    <= `BOOST_RESET;
        ports_4_to_2_drive_boost_reg   <= `BOOST_RESET;
        ctrl_reg      <= ctrl_reg & ~(8'h01 << `CTRL_REGRST_BIT);
        mac_reg       <= `MAC_DEFAULT;
        fs_poll_reg   <= `FS_POLL_DEFAULT;
        hs_poll_reg   <= `HS_POLL_DEFAULT;
        flags_reg     <= `ETH_FLAGS_DEFAULT;
        max_power_reg <= `MAX_POWER_DEFAULT;
      end else if (state_reg == ST_SIG_WAIT && mem_rd_valid &&
                   mem_rd_data != `MEM_SIGNATURE) begin
        mac_reg <= `MAC_DEFAULT;
        if (kind_reg != `LOAD_MAC) begin
          fs_poll_reg <= `FS_POLL_DEFAULT;
          hs_poll_reg <= `HS_POLL_DEFAULT;
          flags_reg   <= `ETH_FLAGS_DEFAULT;
        end
      end else if (load_done_byte) begin
        case (addr_reg)
          8'h01: mac_reg[47:40] <= mem_rd_data;
          8'h02: mac_reg[39:32] <= mem_rd_data;
          8'h03: mac_reg[31:24] <= mem_rd_data;
          8'h04: mac_reg[23:16] <= mem_rd_data;
          8'h05: mac_reg[15:8]  <= mem_rd_data;
          8'h06: mac_reg[7:0]   <= mem_rd_data;
          `MEM_FS_POLL: fs_poll_reg <= mem_rd_data;
          `MEM_HS_POLL: hs_poll_reg <= mem_rd_data;
          `MEM_ETH_FLAGS: flags_reg <= mem_rd_data;
          `MEM_BOOST5: boost5_reg <= mem_rd_data & `BOOST5_MASK;
          `MEM_PORTS_4_TO_2_DRIVE_BOOST: ports_4_to_2_drive_boost_reg <= mem_rd_data & `PORTS_4_TO_2_DRIVE_BOOST_MASK;
          `MEM_ATTACH_CTRL: ctrl_reg <= (mem_rd_data & 8'h01) | ctrl_reg;
          default: mac_reg <= mac_reg;
        endcase
      end else if (bus_wr) begin
        if (sel_boost5 && !protect) begin
          boost5_reg <= avs_writedata[7:0] & `BOOST5_MASK;
        end
        if (sel_ports_4_to_2_drive_boost && !protect) begin
          ports_4_to_2_drive_boost_reg <= avs_writedata[7:0] & `PORTS_4_TO_2_DRIVE_BOOST_MASK;
        end
        if (sel_ctrl) begin
          ctrl_reg <= ctrl_reg | (avs_writedata[7:0] & 8'h03);
        end
      end
    end
  end

  // -----------------------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the answer.
  // -----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else if (clk_en) begin
      if (bus_ack) begin
        wait_reg <= 1'b1;
      end else if (avs_read | avs_write) begin
        wait_reg <= 1'b0;
      end
      if (avs_read && wait_reg) begin
        case (avs_address)
          `ADDR_BOOST5:      rdata_reg <= {24'h000000, boost5_reg};
          `ADDR_PORTS_4_TO_2_DRIVE_BOOST:     rdata_reg <= {24'h000000, ports_4_to_2_drive_boost_reg};
          `ADDR_ATTACH_CTRL: rdata_reg <= {24'h000000, ctrl_reg};
          `ADDR_LOAD_STATUS: rdata_reg <= {30'h0000000, sig_ok_reg, ready_reg};
          `ADDR_MAC_LO:      rdata_reg <= mac_reg[31:0];
          `ADDR_MAC_HI:      rdata_reg <= {16'h0000, mac_reg[47:32]};
          `ADDR_ETH_PARAMS:  rdata_reg <= {max_power_reg, flags_reg, hs_poll_reg, fs_poll_reg};
          default:           rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------------------
  // Drive strength decode, one entry per port.
  // -----------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_level
      wire [1:0] code;
      reg  [4:0] lvl_reg;
      assign code = (i == 0) ? boost5_reg[1:0] : ports_4_to_2_drive_boost_reg[2*i+1:2*i];
      always @(posedge mclk) begin
        if (hw_reset) begin
          lvl_reg <= 5'h00;
        end else if (clk_en) begin
          lvl_reg <= {1'b0, code, 2'b00};
        end
      end
      assign level_bus[5*i+4:5*i] = lvl_reg;
    end
  endgenerate

  assign avs_readdata             = rdata_reg;
  assign avs_waitrequest          = wait_reg;
  assign mem_rd_req               = req_reg;
  assign mem_addr                 = addr_reg;
  assign port5_drive_boost        = boost5_reg;
  assign ports_4_to_2_drive_boost = ports_4_to_2_drive_boost_reg;
  assign attach_and_reset_control = ctrl_reg;
  assign usb_attach               = ctrl_reg[`CTRL_ATTACH_BIT];
  assign port5_drive_level        = level_bus[4:0];
  assign port4_drive_level        = level_bus[19:15];
  assign port3_drive_level        = level_bus[14:10];
  assign port2_drive_level        = level_bus[9:5];
  assign mac_address              = mac_reg;
  assign fs_poll_interval         = fs_poll_reg;
  assign hs_poll_interval         = hs_poll_reg;
  assign eth_config_flags         = flags_reg;
  assign eth_max_power            = max_power_reg;
  assign config_ready             = ready_reg;
  assign signature_valid          = sig_ok_reg;

endmodule

// *** sim/cfg_mem_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial memory; answers a byte read after lat+1 cycles.
// ------------------------------------------------------------
module cfg_mem_model (
  input  wire       mclk,
  input  wire       mem_rd_req,
  input  wire [7:0] mem_addr,
  input  wire [1:0] lat,
  output reg        mem_rd_valid,
  output reg  [7:0] mem_rd_data
);
  reg [7:0] mem [0:255];
  reg [1:0] cnt_reg;
  initial begin
    mem_rd_valid = 1'b0;
    mem_rd_data  = 8'h00;
    cnt_reg      = 2'h0;
  end
  // Data toggles outside the answer; a request still held after its answer is answered again.
  always @(posedge mclk) begin
    mem_rd_valid <= 1'b0;
    mem_rd_data  <= ~mem_rd_data;
    cnt_reg      <= cnt_reg + 2'h1;
    if (!mem_rd_req || mem_rd_valid) begin
      cnt_reg <= 2'h0;
    end else if (cnt_reg == lat) begin
      mem_rd_valid <= 1'b1;
      mem_rd_data  <= mem[mem_addr];
    end
  end
endmodule

// *** sim/eeprom_config_autoload_checker.sv ***
`timescale 1ns/1ps
module eeprom_config_autoload_checker (
  input wire       mclk,
  input wire       rst,
  input wire       external_hw_reset_n,
  input wire       avs_write,
  input wire       avs_waitrequest,
  input wire [7:0] avs_address,
  input wire       mem_rd_req,
  input wire [7:0] mem_addr,
  input wire       mem_rd_valid,
  input wire [7:0] mem_rd_data,
  input wire [7:0] port5_drive_boost,
  input wire [7:0] ports_4_to_2_drive_boost,
  input wire [7:0] attach_and_reset_control,
  input wire       usb_attach,
  input wire [4:0] port5_drive_level,
  input wire [4:0] port2_drive_level,
  input wire       config_ready
);
  wire hrst = rst | ~external_hw_reset_n;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (hrst);
  a_reset_vals:
    assert property ($fell(hrst) |-> port5_drive_boost == 8'h00 &&
      ports_4_to_2_drive_boost == 8'h00 && attach_and_reset_control == 8'h01)
    else $error("register values after reset wrong");
  a_boost_rsvd:
    assert property (port5_drive_boost[7:2] == 6'h00 && ports_4_to_2_drive_boost[1:0] == 2'h0)
    else $error("reserved boost bits set");
  a_level_map:
    assert property (!$past(hrst) |->
      port5_drive_level == {1'b0, $past(port5_drive_boost[1:0]), 2'b00} &&
      port2_drive_level == {1'b0, $past(ports_4_to_2_drive_boost[3:2]), 2'b00})
    else $error("drive level does not match boost code");
  a_attach_keep:
    assert property (usb_attach |=> usb_attach)
    else $error("attach cleared without hardware reset");
  a_wp_boost:
    assert property (avs_write && !avs_waitrequest && usb_attach && !mem_rd_req &&
      (avs_address == 8'h00 || avs_address == 8'h04) |=>
      $stable(port5_drive_boost) && $stable(ports_4_to_2_drive_boost))
    else $error("protected boost register written");
  a_regrst_clear:
    assert property (attach_and_reset_control[1] |=> !attach_and_reset_control[1] &&
      port5_drive_boost == 8'h00 && ports_4_to_2_drive_boost == 8'h00)
    else $error("register reset bit stuck or defaults not restored");
  a_first_sig:
    assert property ($fell(hrst) |=> mem_rd_req && mem_addr == 8'h00)
    else $error("load does not start at byte 0");
  a_bad_sig:
    assert property (mem_rd_valid && mem_rd_req && mem_addr == 8'h00 &&
      mem_rd_data != 8'hA5 |=> (!mem_rd_req)[*2] ##0 config_ready)
    else $error("load continued after bad signature");
  a_ready_hold:
    assert property (mem_rd_req && $past(mem_rd_req) |-> !config_ready)
    else $error("ready shown during load");
  a_addr_hold:
    assert property (mem_rd_req && !mem_rd_valid |=> mem_rd_req && $stable(mem_addr))
    else $error("memory request dropped before answer");
  c_regrst: cover property (attach_and_reset_control[1]);
  c_hub_byte: cover property (mem_rd_valid && mem_addr == 8'h39);
  c_reload: cover property ($fell(config_ready));
endmodule

// *** sim/eeprom_config_autoload_tb.sv ***
`timescale 1ns/1ps
module eeprom_config_autoload_tb;
  reg         mclk;
  reg         rst = 1'b1;
  reg         clk_en = 1'b1;
  reg         external_hw_reset_n = 1'b1;
  reg         usb_bus_reset = 1'b0;
  reg         software_reset = 1'b0;
  reg         reload_cmd = 1'b0;
  reg  [7:0]  avs_address = 8'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  reg  [1:0]  lat = 2'h0;
  reg  [31:0] rdata;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, mem_rd_req, mem_rd_valid, usb_attach, config_ready;
  wire [7:0]  mem_addr, mem_rd_data, port5_drive_boost, ports_4_to_2_drive_boost;
  wire [7:0]  attach_and_reset_control;
  wire [4:0]  port5_drive_level, port4_drive_level, port3_drive_level, port2_drive_level;
  integer     num_errors = 0;
  integer     n_compared = 0;
  integer     i, j;
  // Rows: register address, expected word after a full load.
  localparam logic [39:0] ROWS [8] = '{{8'h00, 32'h2}, {8'h04, 32'hE4}, {8'h08, 32'h1},
    {8'h0C, 32'h3}, {8'h10, 32'h56789ABC}, {8'h14, 32'h1234}, {8'h18, 32'h010C0B0A},
    {8'h20, 32'h0}};
  eeprom_config_autoload u_eeprom_config_autoload (.*, .mac_address(), .fs_poll_interval(),
    .hs_poll_interval(), .eth_config_flags(), .eth_max_power(), .signature_valid());
  cfg_mem_model u_cfg_mem_model (.*);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task chk(input [47:0] got, input [47:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= w;
      avs_read      <= !w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk({16'h0, rdata}, {16'h0, e});
    end
  endtask
  // Bits: 3 hardware reset, 2 bus reset, 1 software reset, 0 reload.
  task pulse(input [3:0] m);
    begin
      @(posedge mclk);
      {usb_bus_reset, software_reset, reload_cmd} <= m[2:0];
      external_hw_reset_n <= !m[3];
      repeat (3) @(posedge mclk);
      {usb_bus_reset, software_reset, reload_cmd} <= 3'h0;
      external_hw_reset_n <= 1'b1;
    end
  endtask
  task wait_load;
    integer k;
    begin
      k = 0;
      while (config_ready !== 1'b0 && k < 50) begin
        @(posedge mclk);
        k = k + 1;
      end
      while (config_ready !== 1'b1 && k < 600) begin
        @(posedge mclk);
        k = k + 1;
      end
      chk({47'h0, config_ready}, 48'h1);
    end
  endtask
  task load_img;
    begin
      for (i = 0; i < 256; i = i + 1) u_cfg_mem_model.mem[i] = 8'hFF;
      for (i = 0; i < 10; i = i + 1)
        u_cfg_mem_model.mem[i] = 80'hA5123456789ABC0A0B0C >> (8 * (9 - i));
      u_cfg_mem_model.mem[8'h32] = 8'h02;
      u_cfg_mem_model.mem[8'h33] = 8'hE4;
      u_cfg_mem_model.mem[8'h39] = 8'h01;
    end
  endtask
  task run_table;
    begin
      for (i = 0; i < 8; i = i + 1) rd(ROWS[i][39:32], ROWS[i][31:0]);
      chk({28'h0, port5_drive_level, port4_drive_level, port3_drive_level,
        port2_drive_level}, 48'h43104);
    end
  endtask
  task end_of_test;
    begin
      $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors = num_errors + 1;
    end_of_test;
  end
  initial begin
    load_img;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wait_load;
    run_table;
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h20, 32'hFF);
    rd(8'h00, 32'h2);
    rd(8'h04, 32'hE4);
    rd(8'h20, 32'h0);
    bus(1'b1, 8'h08, 32'h2);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h1);
    rd(8'h10, 32'hFFFFFFFF);
    rd(8'h18, 32'h01050401);
    lat <= 2'h3;
    u_cfg_mem_model.mem[6] = 8'hC3;
    u_cfg_mem_model.mem[7] = 8'h21;
    pulse(4'h4);
    wait_load;
    rd(8'h10, 32'h56789AC3);
    rd(8'h18, 32'h01050401);
    for (j = 0; j < 2; j = j + 1) begin
      u_cfg_mem_model.mem[8] = 8'h30 + j[7:0];
      pulse(4'h2 >> j);
      repeat (6) @(posedge mclk);
      clk_en <= 1'b0;
      repeat (5) @(posedge mclk);
      clk_en <= 1'b1;
      wait_load;
      rd(8'h18, {16'h010C, 8'h30 + j[7:0], 8'h21});
      rd(8'h00, 32'h0);
    end
    u_cfg_mem_model.mem[0] = 8'h5A;
    pulse(4'h8);
    wait_load;
    rd(8'h0C, 32'h1);
    rd(8'h10, 32'hFFFFFFFF);
    rd(8'h14, 32'hFFFF);
    rd(8'h18, 32'h01050401);
    rd(8'h08, 32'h1);
    load_img;
    lat <= 2'h1;
    pulse(4'h8);
    wait_load;
    run_table;
    end_of_test;
  end
endmodule
bind eeprom_config_autoload eeprom_config_autoload_checker u_chk (.*);
